// File: clk_ctrl_defs.svh
// Constants for the system clock prescaler and oscillator trim block
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// ----------------------------------------------------------------
// Register map (register indices on the plain port)
// ----------------------------------------------------------------
`define CC_ADDR_W           4
`define CC_ADDR_TRIM        4'h0
`define CC_ADDR_DIV_CTRL    4'h1

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define CC_UNLOCK_BIT       7
`define CC_SEL_MSB          3
`define CC_SEL_LSB          0
`define CC_TRIM_RANGE_BIT   7
`define CC_UNLOCK_PATTERN   8'h80
`define CC_RSVD_ZERO        3'h0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CC_SEL_RESET_PLAIN  4'h0
`define CC_SEL_RESET_DIV8   4'h3
`define CC_SEL_MAX          4'h8
`define CC_UNLOCK_CYCLES    3'h4
`define CC_READ_IDLE        8'h00

`endif

// File: clk_ctrl_pkg.sv
// Types shared by the clock control block
`default_nettype none
package clk_ctrl_pkg;
  typedef enum logic {
    UNLOCK_CLOSED,
    UNLOCK_OPEN
  } unlock_state_t;
  typedef logic [3:0] div_select_t;
endpackage
`default_nettype wire

// File: clk_prescale_trim.sv
// System clock prescaler with protected change sequence and RC trim register
//
// Local design decisions: strobed register access and the register offsets.
`include "clk_ctrl_defs.svh"
`default_nettype none
module clk_prescale_trim
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_W = `CC_ADDR_W,
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk_in,
  input  wire logic              resetn_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  input  wire logic              divide_by_eight_fuse_in,
  input  wire logic [7:0]        factory_trim_in,
  input  wire logic              rc_is_system_clock_in,
  input  wire logic              timer_async_request_in,
  input  wire logic              timer_ext_clock_select_in,
  output logic      [3:0]        derived_clk_en_out,
  output logic                   trim_range_select_out,
  output logic      [6:0]        trim_fine_value_out,
  output logic                   timer_osc_enable_out,
  output logic                   timer_osc_ext_mode_out
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Clean unlock pattern: bit 7 set, every other bit zero
  function automatic logic is_clean_unlock(input logic [DATA_W-1:0] data);
    is_clean_unlock = (data == DATA_W'(`CC_UNLOCK_PATTERN));
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  unlock_state_t     unlock_state_r;
  unlock_state_t     unlock_state_nxt;
  logic [2:0]        window_cnt_r;
  logic [2:0]        window_cnt_nxt;
  div_select_t       select_r;
  div_select_t       select_nxt;
  logic [7:0]        trim_r;
  logic [7:0]        trim_nxt;
  logic              straps_taken_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              timer_osc_en_r;
  logic              timer_ext_r;
  logic              hit_trim;
  logic              hit_ctrl;
  logic              wr_trim;
  logic              wr_ctrl;
  logic              wr_unlock;
  logic              wr_select;
  logic              unlock_open;
  logic              window_done;
  logic              divided_tick;
  div_select_t       fuse_select;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hit_trim    = (reg_addr_in == ADDR_W'(`CC_ADDR_TRIM));
  assign hit_ctrl    = (reg_addr_in == ADDR_W'(`CC_ADDR_DIV_CTRL));
  assign wr_trim     = reg_write_in && hit_trim && straps_taken_r;
  assign wr_ctrl     = reg_write_in && hit_ctrl && straps_taken_r;
  assign unlock_open = (unlock_state_r == UNLOCK_OPEN);
  // only a clean pattern opens the window
  assign wr_unlock   = wr_ctrl && !unlock_open && is_clean_unlock(reg_wdata_in);
  // select accepted only inside the window, with unlock written zero
  assign wr_select   = wr_ctrl && unlock_open && !reg_wdata_in[`CC_UNLOCK_BIT];
  assign window_done = (window_cnt_r == 3'h1);
  assign fuse_select = divide_by_eight_fuse_in ? `CC_SEL_RESET_DIV8 : `CC_SEL_RESET_PLAIN;

  // ----------------------------------------------------------------
  // Unlock window sequencing
  // ----------------------------------------------------------------
  always_comb begin
    unlock_state_nxt = unlock_state_r;
    window_cnt_nxt   = window_cnt_r;
    case (unlock_state_r)
      UNLOCK_CLOSED: begin
        if (wr_unlock) begin
          unlock_state_nxt = UNLOCK_OPEN;
          window_cnt_nxt   = `CC_UNLOCK_CYCLES;
        end
      end
      UNLOCK_OPEN: begin
        // unlock rewrites fall through and leave the count running
        // close on timeout or on select write
        if (wr_select || window_done) begin
          unlock_state_nxt = UNLOCK_CLOSED;
          window_cnt_nxt   = 3'h0;
        end else begin
          window_cnt_nxt   = window_cnt_r - 3'h1;
        end
      end
      default: begin
        unlock_state_nxt = UNLOCK_CLOSED;
        window_cnt_nxt   = 3'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Select and trim next values
  // ----------------------------------------------------------------
  // any code loads, fuse plays no part after reset
  assign select_nxt = !straps_taken_r ? fuse_select :
                      wr_select ? reg_wdata_in[`CC_SEL_MSB:`CC_SEL_LSB] : select_r;
  // factory value at reset, software rewrite later
  assign trim_nxt   = !straps_taken_r ? factory_trim_in :
                      wr_trim ? reg_wdata_in[7:0] : trim_r;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // control register shows only unlock and select, never the counter
  assign rdata_nxt = !reg_read_in ? DATA_W'(`CC_READ_IDLE) :
                     hit_trim ? DATA_W'(trim_r) :
                     hit_ctrl ? DATA_W'({unlock_open, `CC_RSVD_ZERO, select_r}) :
                     DATA_W'(`CC_READ_IDLE);

  // Control registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      unlock_state_r <= UNLOCK_CLOSED;
      window_cnt_r   <= 3'h0;
      select_r       <= `CC_SEL_RESET_PLAIN;
      trim_r         <= 8'h00;
      straps_taken_r <= 1'b0;
      rdata_r        <= '0;
    end else begin
      unlock_state_r <= unlock_state_nxt;
      window_cnt_r   <= window_cnt_nxt;
      select_r       <= select_nxt;
      trim_r         <= trim_nxt;
      straps_taken_r <= 1'b1;
      rdata_r        <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------
  // Timer oscillator pin sharing
  // ----------------------------------------------------------------
  // pins usable only with the RC oscillator as system clock
  // crystal or external clock mode follows the select bit
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_osc_en_r <= 1'b0;
      timer_ext_r    <= 1'b0;
    end else begin
      timer_osc_en_r <= timer_async_request_in && rc_is_system_clock_in;
      timer_ext_r    <= timer_ext_clock_select_in;
    end
  end

  assign timer_osc_enable_out   = timer_osc_en_r;
  assign timer_osc_ext_mode_out = timer_ext_r;

  // ----------------------------------------------------------------
  // Oscillator trim outputs
  // ----------------------------------------------------------------
  // range bit drives the oscillator band select
  // fine code passed straight to the tuning ladder
  assign trim_range_select_out = trim_r[`CC_TRIM_RANGE_BIT];
  assign trim_fine_value_out   = trim_r[6:0];

  // ----------------------------------------------------------------
  // Divided clock enables
  // ----------------------------------------------------------------
  // divider takes the new code at the next period end
  clk_ratio_divider #(
    .CNT_W (8)
  ) u_divider (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .select_in  (select_r),
    .tick_out   (divided_tick)
  );

  // I/O, ADC, CPU and flash enables share one tick
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_clk_en
      assign derived_clk_en_out[g] = divided_tick;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unlock_clean_only;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_ctrl && !unlock_open && !is_clean_unlock(reg_wdata_in)) |-> ##1 !unlock_open;
  endproperty
  a_unlock_clean_only: assert property (p_unlock_clean_only) else $error("dirty unlock opened");

  property p_unlock_sets;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_write_in && hit_ctrl && straps_taken_r && !unlock_open &&
       reg_wdata_in == DATA_W'(`CC_UNLOCK_PATTERN)) |-> ##1 unlock_open;
  endproperty
  a_unlock_sets: assert property (p_unlock_sets) else $error("clean unlock ignored");

  property p_unlock_timeout;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (wr_unlock ##1 (!wr_select)[*3]) |-> ##1 unlock_open ##1 !unlock_open;
  endproperty
  a_unlock_timeout: assert property (p_unlock_timeout) else $error("window not four cycles");

  property p_select_locked;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (straps_taken_r && !(reg_write_in && hit_ctrl && unlock_open)) |-> ##1 $stable(select_r);
  endproperty
  a_select_locked: assert property (p_select_locked) else $error("select changed while locked");

  property p_select_load;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_write_in && hit_ctrl && unlock_open && !reg_wdata_in[7]) |->
        ##1 (select_r == $past(reg_wdata_in[3:0]) && !unlock_open);
  endproperty
  a_select_load: assert property (p_select_load) else $error("select write not taken");

  property p_rewrite_no_extend;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (unlock_open && window_cnt_r > 3'h1 && wr_ctrl && reg_wdata_in[`CC_UNLOCK_BIT]) |->
        ##1 (unlock_open && window_cnt_r == $past(window_cnt_r) - 3'h1);
  endproperty
  a_rewrite_no_extend: assert property (p_rewrite_no_extend) else $error("window restarted");

  property p_reserved_read_zero;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_read_in && hit_ctrl) |-> ##1 (reg_rdata_out[6:4] == 3'h0 &&
        reg_rdata_out[3:0] == $past(select_r));
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero) else $error("ctrl read wrong");

  property p_fuse_reset;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (resetn_in && !straps_taken_r) |-> ##1
        (select_r == ($past(divide_by_eight_fuse_in) ? `CC_SEL_RESET_DIV8 :
                                                        `CC_SEL_RESET_PLAIN));
  endproperty
  a_fuse_reset: assert property (p_fuse_reset) else $error("fuse reset value wrong");

  property p_timer_osc_gate;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (timer_async_request_in && !rc_is_system_clock_in) |-> ##1 !timer_osc_enable_out;
  endproperty
  a_timer_osc_gate: assert property (p_timer_osc_gate) else $error("timer osc on crystal");

  property p_trim_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      wr_trim |-> ##1 ({trim_range_select_out, trim_fine_value_out} == $past(reg_wdata_in));
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write not taken");

  property p_trim_reset;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (resetn_in && !straps_taken_r) |->
        ##1 ({trim_range_select_out, trim_fine_value_out} == $past(factory_trim_in));
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim reset wrong");

  property p_rdata_idle;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      !reg_read_in |-> ##1 (reg_rdata_out == DATA_W'(`CC_READ_IDLE));
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_timer_osc_on;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (resetn_in && timer_async_request_in && rc_is_system_clock_in) |-> ##1 timer_osc_enable_out;
  endproperty
  a_timer_osc_on: assert property (p_timer_osc_on) else $error("timer osc not on");

  property p_ext_follow;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      resetn_in |-> ##1 (timer_osc_ext_mode_out == $past(timer_ext_clock_select_in));
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("ext mode stale");

  property p_unlock_read;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (reg_read_in && hit_ctrl) |-> ##1 (reg_rdata_out[`CC_UNLOCK_BIT] == $past(unlock_open));
  endproperty
  a_unlock_read: assert property (p_unlock_read) else $error("unlock bit read wrong");

endmodule
`default_nettype wire

// File: clk_prescale_trim_tb.sv
// Self-checking testbench for the clock prescaler and trim block
`include "clk_ctrl_defs.svh"
`default_nettype none
module clk_prescale_trim_tb
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic       clk     = 1'b0;
  logic       resetn  = 1'b0;
  logic [3:0] addr    = 4'h0;
  logic [7:0] wdata   = 8'h00;
  logic       we      = 1'b0;
  logic       re      = 1'b0;
  logic       fuse    = 1'b1;
  logic [7:0] ftrim   = 8'ha5;
  logic       rc_sel  = 1'b0;
  logic       t_req   = 1'b0;
  logic       t_ext   = 1'b0;
  logic [7:0] rdata;
  logic [3:0] clk_en;
  logic       t_rng;
  logic [6:0] t_fine;
  logic       t_en;
  logic       t_xm;
  int         n_errors  = 0;
  int         tests_run = 0;
  logic [7:0] rv;

  clk_prescale_trim i_dut (
    .ref_clk_in                (clk),
    .resetn_in                 (resetn),
    .reg_addr_in               (addr),
    .reg_wdata_in              (wdata),
    .reg_write_in              (we),
    .reg_read_in               (re),
    .reg_rdata_out             (rdata),
    .divide_by_eight_fuse_in   (fuse),
    .factory_trim_in           (ftrim),
    .rc_is_system_clock_in     (rc_sel),
    .timer_async_request_in    (t_req),
    .timer_ext_clock_select_in (t_ext),
    .derived_clk_en_out        (clk_en),
    .trim_range_select_out     (t_rng),
    .trim_fine_value_out       (t_fine),
    .timer_osc_enable_out      (t_en),
    .timer_osc_ext_mode_out    (t_xm)
  );

  // 40 MHz master clock
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Byte compare, widened on purpose
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check16({8'h00, got}, {8'h00, exp}, what);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    re    <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b0;
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    we   <= 1'b0;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_sel(input logic [3:0] code);
    wr(`CC_ADDR_DIV_CTRL, `CC_UNLOCK_PATTERN);
    wr(`CC_ADDR_DIV_CTRL, {4'h0, code});
    idle(1);
  endtask

  // Cycles from one enable pulse to the next, bounded
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (clk_en[0] !== 1'b1 && c < 600);
  endtask

  // Skips the changeover period, then measures one full period
  task automatic period_chk(input logic [3:0] code);
    int c;
    gap(c);
    gap(c);
    gap(c);
    check16(16'(c), (code > 4'h8) ? 16'd256 : (16'd1 << code), "period");
    check16({12'h0, clk_en}, 16'h000f, "enables differ");
  endtask

  // Pulse spacing and settling across a division change
  task automatic change_chk(input logic [3:0] o, input logic [3:0] n);
    int c, k, last, bad, t1, t2;
    t1 = 1 << o;
    t2 = 1 << n;
    set_sel(o);
    period_chk(o);
    wr(`CC_ADDR_DIV_CTRL, 8'h80);
    wr(`CC_ADDR_DIV_CTRL, {4'h0, n});
    idle(1);
    c = 0; k = 0; last = 0; bad = 0;
    while (k < 2 && c < 600) begin
      @(posedge clk);
      #1 c++;
      if (clk_en[0] === 1'b1) begin
        if (k > 0 && (c - last < (t1 < t2 ? t1 : t2) || c - last > (t1 > t2 ? t1 : t2)))
          bad++;
        k++;
        last = c;
      end
    end
    check16(16'(c <= t1 + 2 * t2), 16'h1, "settle time");
    check16(16'(bad), 16'h0, "odd pulse spacing");
  endtask

  // Ends the run with the verdict
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog against a hung wait
  // ----------------------------------------------------------------
  initial begin
    #1000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    idle(2);
    // Reset values with fuse programmed
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h03, "ctrl reset fuse");
    rd(`CC_ADDR_TRIM, rv); check(rv, 8'ha5, "trim reset");
    check({t_rng, t_fine}, 8'ha5, "trim pins reset");
    period_chk(4'h3);
    // Trim rewrite, range boundary values
    for (int i = 0; i < 3; i++) begin
      logic [7:0] v;
      v = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'h00;
      wr(`CC_ADDR_TRIM, v);
      rd(`CC_ADDR_TRIM, rv); check(rv, v, "trim rw");
      check({t_rng, t_fine}, v, "trim pins");
    end
    // Unmapped address and idle read data
    wr(4'h7, 8'hff);
    rd(4'h7, rv); check(rv, 8'h00, "unmapped read");
    idle(1);
    #1 check(rdata, 8'h00, "idle rdata");
    // Locked select, unlock with stray bits
    set_sel(4'h2);
    wr(`CC_ADDR_DIV_CTRL, 8'h05);
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h02, "locked write");
    wr(`CC_ADDR_DIV_CTRL, 8'h81);
    wr(`CC_ADDR_DIV_CTRL, 8'h05);
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h02, "stray unlock");
    // Window edges: select write one to five cycles after unlock
    for (int k = 1; k <= 5; k++) begin
      set_sel(4'h2);
      wr(`CC_ADDR_DIV_CTRL, 8'h80);
      idle(k - 1);
      wr(`CC_ADDR_DIV_CTRL, 8'h75);
      idle(1);
      rd(`CC_ADDR_DIV_CTRL, rv); check(rv, (k <= 4) ? 8'h05 : 8'h02, "window");
    end
    // Second unlock inside the window
    set_sel(4'h2);
    wr(`CC_ADDR_DIV_CTRL, 8'h80);
    idle(1);
    wr(`CC_ADDR_DIV_CTRL, 8'h80);
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h82, "rewrite kept");
    wr(`CC_ADDR_DIV_CTRL, 8'h06);
    idle(1);
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h02, "no extension");
    // Select codes 0 to 9, reserved code 9 included
    for (int c = 0; c <= 9; c++) begin
      set_sel(4'(c));
      rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'(c), "select stored");
      period_chk(4'(c));
    end
    // Division changes up and down
    change_chk(4'h3, 4'h1);
    change_chk(4'h1, 4'h4);
    change_chk(4'h2, 4'h0);
    // Timer oscillator pin rules
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {rc_sel, t_req, t_ext} <= 3'(i);
      idle(2);
      #1 check({6'h00, t_en, t_xm}, {6'h00, rc_sel & t_req, t_ext}, "timer osc");
    end
    // Second reset with fuse unprogrammed
    @(posedge clk);
    resetn <= 1'b0;
    fuse   <= 1'b0;
    ftrim  <= 8'h3c;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    idle(2);
    rd(`CC_ADDR_DIV_CTRL, rv); check(rv, 8'h00, "ctrl reset plain");
    rd(`CC_ADDR_TRIM, rv); check(rv, 8'h3c, "trim reload");
    period_chk(4'h0);
    test_done();
  end
endmodule
`default_nettype wire

// File: clk_ratio_divider.sv
// Glitch-free power-of-two clock enable divider
`include "clk_ctrl_defs.svh"
`default_nettype none
module clk_ratio_divider
  import clk_ctrl_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire div_select_t select_in,
  output logic             tick_out
);

  // ----------------------------------------------------------------
  // Divider state
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  div_select_t      active_sel_r;
  logic             tick_r;
  logic             boundary;
  div_select_t      clamped_sel;

  // Reserved codes behave as the largest factor
  assign clamped_sel = (select_in > `CC_SEL_MAX) ? `CC_SEL_MAX : select_in;
  assign boundary    = (count_r == '0);
  // reload value is two to the power of the code, minus one
  assign count_nxt   = boundary ? CNT_W'((1 << clamped_sel) - 1) : count_r - CNT_W'(1);
  assign tick_out    = tick_r;

  // Synchronous down count on the undivided clock; new code taken only at a period end
  // switch only at a boundary, no partial period
  // old period always completes, so none runs shorter
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r      <= '0;
      active_sel_r <= `CC_SEL_RESET_PLAIN;
      tick_r       <= 1'b0;
    end else begin
      count_r      <= count_nxt;
      tick_r       <= boundary;
      if (boundary) begin
        active_sel_r <= clamped_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unity_ratio;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (boundary && clamped_sel == `CC_SEL_RESET_PLAIN) |-> ##1 boundary ##1 tick_r;
  endproperty
  a_unity_ratio: assert property (p_unity_ratio) else $error("factor one not every cycle");

  property p_no_short_pulse;
    @(posedge ref_clk_in) disable iff (!resetn_in)
      (tick_r && active_sel_r == `CC_SEL_RESET_DIV8) |-> ##1 (!tick_r)[*7];
  endproperty
  a_no_short_pulse: assert property (p_no_short_pulse) else $error("divide by eight too fast");

endmodule
`default_nettype wire
